// file: common/src_pkg.sv
/*
  Shared constants and carriers for the reliability command interpreter.
  Assumes a 20 MHz system clock and a host that loads the task file
  before pulsing the command strobe.
*/
package src_pkg;
  // ---------------------------------------------------------------
  // Command and key codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RELIAB   = 8'hB0;
  localparam logic [7:0] SUB_STATUS   = 8'hDA;
  localparam logic [7:0] SUB_ATTRIBUTE_AUTO_STORE = 8'hD2;
  localparam logic [7:0] SUB_SAVE     = 8'hD3;
  localparam logic [7:0] SUB_AUTOOFF  = 8'hDB;
  localparam logic [7:0] SUB_ENABLE   = 8'hD8;
  localparam logic [7:0] SUB_DISABLE  = 8'hD9;
  localparam logic [7:0] KEY_CYL_LO   = 8'h4F;
  localparam logic [7:0] KEY_CYL_HI   = 8'hC2;
  localparam logic [7:0] BAD_CYL_LO   = 8'hF4;
  localparam logic [7:0] BAD_CYL_HI   = 8'h2C;
  localparam logic [7:0] CNT_OFF      = 8'h00;
  localparam logic [7:0] CNT_AS_ON    = 8'hF1;
  localparam logic [7:0] CNT_AO_ON    = 8'hF8;
  localparam int         DSEL_BIT     = 4;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int  CLK_HZ         = 20_000_000;
  localparam int  RESP_LIMIT_S   = 2;
  localparam int  IDLE_MIN       = 2;
  localparam int  SCAN_PART_POH  = 24;
  localparam int  SCAN_FULL_POH  = 168;
  localparam longint RESP_CYC = longint'(RESP_LIMIT_S) * CLK_HZ;
  localparam longint IDLE_CYC = longint'(IDLE_MIN) * 60 * CLK_HZ;
  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] feat;
    logic [7:0] sec_cnt;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] dev_head;
    logic [7:0] cmd;
  } src_tf_t;

  typedef struct packed {
    logic       bsy;
    logic       drdy;
    logic       err;
    logic       abrt;
    logic       intrq;
  } src_stat_t;
endpackage

// file: rtl/src_core.sv
/*
  Reliability subcommand interpreter: decodes the task file, steers the
  non-volatile store and background collection, answers status codes.
  Assumes the store and scan engines answer with done pulses.
*/
// Notes on behaviour
// RULE_01: Host selects status with features DAh, keys, then command B0h.
// RULE_02: Status request raises busy, stores changed values, then compares.
// RULE_03: No threshold crossed: cylinder low 4Fh, cylinder high C2h.
// RULE_04: Threshold crossed: cylinder low F4h, cylinder high 2Ch.
// RULE_05: Status and save abort if monitoring off or keys wrong.
// RULE_06: Attribute_auto_store D2h: count 00h turns off, F1h turns on.
// RULE_07: Host writes wanted attribute_auto_store code in sector count first.
// RULE_08: Attribute_auto_store setting is held in non-volatile storage.
// RULE_09: With attribute_auto_store off, other activity may still store values.
// RULE_10: Attribute_auto_store command: busy, apply, drop busy, then interrupt.
// RULE_11: Background attribute_auto_store keeps busy low and ready high.
// RULE_12: Command during background attribute_auto_store is serviced within two seconds.
// RULE_13: Save D3h stores values now, busy then clear, then interrupt.
// RULE_14: Off-line DBh: count 00h turns off, F8h turns on.
// RULE_15: Partial scan every 24 power-on hours after 2 idle minutes.
// RULE_16: Full scan every 168 power-on hours after 2 idle minutes.
// RULE_17: Automatic off-line stays on until disabled by the host.
// RULE_18: Off-line command: busy, apply, clear busy, then interrupt.
// RULE_19: During off-line collection and its save, ready and busy low.
// RULE_20: Command during off-line collection answered within two seconds.
// RULE_21: Host picks device with the drive-select bit, 0 first, 1 second.
// RULE_22: With monitoring off, all subcommands but enable are aborted.
// RULE_23: Host waits for busy low before writing the next command.
`timescale 1ns/1ps
module src_core
  import src_pkg::*;
#(
  parameter logic       DEV_ID    = 1'b0,
  parameter longint     RESP_MAX  = RESP_CYC,
  parameter longint     IDLE_WAIT = IDLE_CYC
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Host task file
  input  wire logic              cmd_stb,
  input  wire src_pkg::src_tf_t  tf,
  input  wire logic              intrq_clr,
  output logic [7:0]             cyl_lo_out,
  output logic [7:0]             cyl_hi_out,
  output src_pkg::src_stat_t     stat,
  // Non-volatile settings, loaded at power-up
  input  wire logic              nv_load,
  input  wire logic              nv_mon_en,
  input  wire logic              nv_as_en,
  input  wire logic              nv_ao_en,
  output logic                   nv_mon_en_r,
  output logic                   nv_as_en_r,
  output logic                   nv_ao_en_r,
  // Attribute store and compare engine
  output logic                   store_req,
  input  wire logic              store_done,
  input  wire logic              thresh_crossed,
  input  wire logic              bg_store_req,
  // Off-line scan engine
  input  wire logic              poh_tick,
  output logic                   scan_part_req,
  output logic                   scan_full_req,
  output logic                   scan_halt,
  input  wire logic              scan_done
);
  import src_pkg::*;

  // ---------------------------------------------------------------
  // State and decode
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_IDLE = 3'b000, SRC_EXEC = 3'b001, SRC_STORE = 3'b011,
    SRC_DONE = 3'b010, SRC_BG = 3'b110
  } src_st_t;

  src_st_t     st_r;
  logic [1:0]  bg_kind_r;   // 1 attribute_auto_store, 2 part scan, 3 full scan
  logic [7:0]  feat_r;
  logic [7:0]  cnt_r;
  logic        keys_ok_r;
  logic        abort_r;
  logic [7:0]  poh_cnt_r;
  logic [63:0] idle_r;
  logic [63:0] wait_r;
  logic        part_due_r;
  logic        full_due_r;
  logic        mine;
  logic        keys_ok;
  logic        bsy_w;
  logic        drdy_w;
  logic        err_r;
  logic        abrt_r;
  logic        intrq_r;

  // Strobe is taken only while idle or in background work
  assign mine    = cmd_stb && (st_r == SRC_IDLE || st_r == SRC_BG) &&
                   tf.cmd == CMD_RELIAB &&
                   tf.dev_head[DSEL_BIT] == DEV_ID;              // [RULE_21]
  assign keys_ok = tf.cyl_lo == KEY_CYL_LO && tf.cyl_hi == KEY_CYL_HI;

  // Main sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r      <= SRC_IDLE;
      bg_kind_r <= 2'h0;
      feat_r    <= 8'h00;
      cnt_r     <= 8'h00;
      keys_ok_r <= 1'b0;
      abort_r   <= 1'b0;
    end else begin
      case (st_r)
        SRC_IDLE, SRC_BG: begin
          if (mine) begin
            // Foreground command pre-empts background work [RULE_12]
            feat_r    <= tf.feat;                                // [RULE_01]
            cnt_r     <= tf.sec_cnt;                             // [RULE_07]
            keys_ok_r <= keys_ok;
            st_r      <= SRC_EXEC;
          end else if (st_r == SRC_BG && (scan_done || store_done)) begin
            st_r <= SRC_IDLE;
          end else if (st_r == SRC_IDLE && nv_mon_en_r &&
                       (bg_store_req && nv_as_en_r)) begin
            bg_kind_r <= 2'h1;                                   // [RULE_11]
            st_r      <= SRC_BG;
          end else if (st_r == SRC_IDLE && nv_ao_en_r &&
                       (part_due_r || full_due_r) &&
                       idle_r >= IDLE_WAIT) begin
            bg_kind_r <= full_due_r ? 2'h3 : 2'h2;   // [RULE_15] [RULE_16]
            st_r      <= SRC_BG;
          end
        end
        SRC_EXEC: begin
          abort_r <= 1'b0;
          if (!nv_mon_en_r && feat_r != SUB_ENABLE) begin
            abort_r <= 1'b1;                                     // [RULE_22]
            st_r    <= SRC_DONE;
          end else if (!keys_ok_r) begin
            abort_r <= 1'b1;                                     // [RULE_05]
            st_r    <= SRC_DONE;
          end else if (feat_r == SUB_STATUS || feat_r == SUB_SAVE) begin
            st_r <= SRC_STORE;                       // [RULE_02] [RULE_13]
          end else if (feat_r == SUB_ATTRIBUTE_AUTO_STORE &&
                       !(cnt_r == CNT_OFF || cnt_r == CNT_AS_ON)) begin
            abort_r <= 1'b1;
            st_r    <= SRC_DONE;
          end else if (feat_r == SUB_AUTOOFF &&
                       !(cnt_r == CNT_OFF || cnt_r == CNT_AO_ON)) begin
            abort_r <= 1'b1;
            st_r    <= SRC_DONE;
          end else if (feat_r == SUB_ATTRIBUTE_AUTO_STORE || feat_r == SUB_AUTOOFF ||
                       feat_r == SUB_ENABLE || feat_r == SUB_DISABLE) begin
            st_r <= SRC_DONE;                        // [RULE_10] [RULE_18]
          end else begin
            abort_r <= 1'b1;
            st_r    <= SRC_DONE;
          end
        end
        SRC_STORE: begin
          if (store_done) begin
            st_r <= SRC_DONE;
          end
        end
        SRC_DONE: begin
          st_r <= SRC_IDLE;
        end
        default: begin
          st_r <= SRC_IDLE;
        end
      endcase
    end
  end

  // Stored settings; the outer store keeps them across power loss
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nv_mon_en_r <= 1'b0;
      nv_as_en_r  <= 1'b0;
      nv_ao_en_r  <= 1'b0;
    end else if (nv_load) begin
      nv_mon_en_r <= nv_mon_en;
      nv_as_en_r  <= nv_as_en;                                   // [RULE_08]
      nv_ao_en_r  <= nv_ao_en;
    end else if (st_r == SRC_EXEC && keys_ok_r &&
                 (nv_mon_en_r || feat_r == SUB_ENABLE)) begin
      if (feat_r == SUB_ENABLE) begin
        nv_mon_en_r <= 1'b1;
      end else if (feat_r == SUB_DISABLE) begin
        nv_mon_en_r <= 1'b0;
      end else if (feat_r == SUB_ATTRIBUTE_AUTO_STORE && cnt_r == CNT_OFF) begin
        nv_as_en_r <= 1'b0;                                      // [RULE_06]
      end else if (feat_r == SUB_ATTRIBUTE_AUTO_STORE && cnt_r == CNT_AS_ON) begin
        nv_as_en_r <= 1'b1;                                      // [RULE_06]
      end else if (feat_r == SUB_AUTOOFF && cnt_r == CNT_OFF) begin
        nv_ao_en_r <= 1'b0;                          // [RULE_14] [RULE_17]
      end else if (feat_r == SUB_AUTOOFF && cnt_r == CNT_AO_ON) begin
        nv_ao_en_r <= 1'b1;                                      // [RULE_14]
      end
    end
  end

  // Power-on-hour schedule and host idle time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      poh_cnt_r  <= 8'h00;
      part_due_r <= 1'b0;
      full_due_r <= 1'b0;
      idle_r     <= 64'h0;
    end else begin
      idle_r <= cmd_stb ? 64'h0 : (idle_r == IDLE_WAIT ? idle_r
                                   : idle_r + 64'h1);
      // Finished scan clears its flags; a due tick below wins
      if (st_r == SRC_BG && scan_done) begin
        if (bg_kind_r == 2'h3) begin
          full_due_r <= 1'b0;
        end
        part_due_r <= 1'b0;
      end
      if (poh_tick) begin
        if (poh_cnt_r == 8'(SCAN_FULL_POH - 1)) begin
          poh_cnt_r <= 8'h00;
        end else begin
          poh_cnt_r <= poh_cnt_r + 8'h01;
        end
        if (8'(32'(poh_cnt_r + 8'h01) % SCAN_PART_POH) == 8'h00) begin
          part_due_r <= 1'b1;                                    // [RULE_15]
        end
        if (poh_cnt_r == 8'(SCAN_FULL_POH - 1)) begin
          full_due_r <= 1'b1;                                    // [RULE_16]
        end
      end
    end
  end

  // Answer registers, error and interrupt request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyl_lo_out <= KEY_CYL_LO;
      cyl_hi_out <= KEY_CYL_HI;
      err_r      <= 1'b0;
      abrt_r     <= 1'b0;
      intrq_r    <= 1'b0;
    end else begin
      if (mine) begin
        intrq_r <= 1'b0;
      end else if (st_r == SRC_DONE) begin
        intrq_r <= 1'b1;                             // [RULE_10] [RULE_13]
        err_r   <= abort_r;
        abrt_r  <= abort_r;                                      // [RULE_05]
        if (!abort_r && feat_r == SUB_STATUS) begin
          cyl_lo_out <= thresh_crossed ? BAD_CYL_LO : KEY_CYL_LO; // [RULE_03]
          cyl_hi_out <= thresh_crossed ? BAD_CYL_HI : KEY_CYL_HI; // [RULE_04]
        end
      end else if (intrq_clr) begin
        intrq_r <= 1'b0;
      end
    end
  end

  // Response watchdog for pre-empted background work
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_r <= 64'h0;
    end else if (st_r == SRC_EXEC || st_r == SRC_STORE) begin
      wait_r <= wait_r + 64'h1;
    end else begin
      wait_r <= 64'h0;
    end
  end

  // Status lines and engine strobes
  always_comb begin
    bsy_w  = st_r == SRC_EXEC || st_r == SRC_STORE || st_r == SRC_DONE;
    // Off-line scan drops ready, attribute_auto_store keeps it  [RULE_11] [RULE_19]
    drdy_w = !(bsy_w || (st_r == SRC_BG && bg_kind_r != 2'h1));
  end
  assign stat          = {bsy_w, drdy_w, err_r, abrt_r, intrq_r};
  assign store_req     = st_r == SRC_STORE ||
                         (st_r == SRC_BG && bg_kind_r == 2'h1); // [RULE_09]
  assign scan_part_req = st_r == SRC_BG && bg_kind_r == 2'h2;
  assign scan_full_req = st_r == SRC_BG && bg_kind_r == 2'h3;
  assign scan_halt     = mine;                                   // [RULE_20]

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb_chk @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_status_req;
    st_r == SRC_EXEC && feat_r == SUB_STATUS && nv_mon_en_r && keys_ok_r;
  endsequence

  a_status_store: assert property ( // [RULE_02]
    s_status_req |=> st_r == SRC_STORE && store_req && stat.bsy)
    else $error("status did not store under busy");
  a_good_code: assert property ( // [RULE_03]
    st_r == SRC_DONE && !abort_r && feat_r == SUB_STATUS && !thresh_crossed
    |=> cyl_lo_out == 8'h4F && cyl_hi_out == 8'hC2)
    else $error("good status code wrong");
  a_bad_code: assert property ( // [RULE_04]
    st_r == SRC_DONE && !abort_r && feat_r == SUB_STATUS && thresh_crossed
    |=> cyl_lo_out == 8'hF4 && cyl_hi_out == 8'h2C)
    else $error("bad status code wrong");
  a_key_abort: assert property ( // [RULE_05]
    st_r == SRC_EXEC && !keys_ok_r |=> ##1 stat.abrt && stat.intrq)
    else $error("bad keys not aborted");
  a_off_abort: assert property ( // [RULE_22]
    st_r == SRC_EXEC && !nv_mon_en_r && feat_r != SUB_ENABLE
    |=> ##1 stat.abrt)
    else $error("disabled command not aborted");
  a_attribute_auto_store_set: assert property ( // [RULE_06]
    st_r == SRC_EXEC && nv_mon_en_r && keys_ok_r && !nv_load &&
    feat_r == SUB_ATTRIBUTE_AUTO_STORE && cnt_r == CNT_AS_ON |=> nv_as_en_r)
    else $error("attribute_auto_store not enabled");
  a_busy_irq: assert property ( // [RULE_10]
    st_r == SRC_DONE && !mine |=> !stat.bsy && stat.intrq)
    else $error("interrupt not after busy");
  a_bg_lines: assert property ( // [RULE_19]
    st_r == SRC_BG && bg_kind_r != 2'h1 |-> !stat.bsy && !stat.drdy)
    else $error("off-line lines wrong");
  a_as_lines: assert property ( // [RULE_11]
    st_r == SRC_BG && bg_kind_r == 2'h1 |-> !stat.bsy && stat.drdy)
    else $error("attribute_auto_store lines wrong");
  a_resp_time: assert property ( // [RULE_12]
    wait_r <= RESP_MAX)
    else $error("command not serviced in time");
  a_preempt: assert property ( // [RULE_20]
    st_r == SRC_BG && mine |=> st_r == SRC_EXEC && stat.bsy)
    else $error("background not pre-empted");
endmodule

// file: dv/src_eng_model.sv
/*
  Store and scan engine model facing the reliability interpreter.
  Assumes one clock; answers each request with a one-cycle done pulse.
*/
`timescale 1ns/1ps
module src_eng_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Attribute store
  input  wire logic store_req,
  output logic      store_done,
  // Off-line scan
  input  wire logic scan_part_req,
  input  wire logic scan_full_req,
  input  wire logic scan_halt,
  output logic      scan_done
);
  int s_cnt;
  int c_cnt;
  // Store answers after a random 4 to 11 cycles
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      store_done <= 1'b0;
      s_cnt      <= 0;
    end else begin
      store_done <= 1'b0;
      if (!store_req || store_done) s_cnt <= 0;
      else if (s_cnt == 0) s_cnt <= 4 + $urandom_range(7);
      else if (s_cnt == 1) store_done <= 1'b1;
      else s_cnt <= s_cnt - 1;
    end
  end
  // Scan runs 12 cycles, dropped on a halt
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_done <= 1'b0;
      c_cnt     <= 0;
    end else begin
      scan_done <= 1'b0;
      if (!(scan_part_req || scan_full_req) || scan_halt || scan_done)
        c_cnt <= 0;
      else if (c_cnt == 12) scan_done <= 1'b1;
      else c_cnt <= c_cnt + 1;
    end
  end
endmodule

// file: dv/tb.sv
/*
  Self-checking bench for the reliability command interpreter.
  Assumes src_core with shortened response and idle counts.
*/
`timescale 1ns/1ps
module tb;
  import src_pkg::*;
  localparam int W = 60;
  logic       clk, rst, cmd_stb, intrq_clr, nv_load, iq_q;
  logic       nv_mon_en, nv_as_en, nv_ao_en, store_req, store_done;
  logic       thresh_crossed, bg_store_req, poh_tick, scan_halt;
  logic       scan_part_req, scan_full_req, scan_done;
  logic       nv_mon_en_r, nv_as_en_r, nv_ao_en_r;
  logic [7:0] cyl_lo_out, cyl_hi_out;
  logic [7:0] ast [3];
  logic [17:0] exp_q [$];
  logic [17:0] e;
  src_tf_t    tf;
  src_stat_t  stat;
  int         errors, n_checks, i;
  // ---------------------------------------------------------------
  // Design and engine
  // ---------------------------------------------------------------
  src_core #(.RESP_MAX(50), .IDLE_WAIT(20)) u_src_core (
    .clk(clk), .rst(rst), .cmd_stb(cmd_stb), .tf(tf),
    .intrq_clr(intrq_clr), .cyl_lo_out(cyl_lo_out),
    .cyl_hi_out(cyl_hi_out), .stat(stat), .nv_load(nv_load),
    .nv_mon_en(nv_mon_en), .nv_as_en(nv_as_en), .nv_ao_en(nv_ao_en),
    .nv_mon_en_r(nv_mon_en_r), .nv_as_en_r(nv_as_en_r),
    .nv_ao_en_r(nv_ao_en_r), .store_req(store_req),
    .store_done(store_done), .thresh_crossed(thresh_crossed),
    .bg_store_req(bg_store_req), .poh_tick(poh_tick),
    .scan_part_req(scan_part_req), .scan_full_req(scan_full_req),
    .scan_halt(scan_halt), .scan_done(scan_done));
  src_eng_model u_src_eng_model (
    .clk(clk), .rst(rst), .store_req(store_req),
    .store_done(store_done), .scan_part_req(scan_part_req),
    .scan_full_req(scan_full_req), .scan_halt(scan_halt),
    .scan_done(scan_done));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] s, x);
    n_checks++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Bounded wait on intrq, store, part scan or full scan
  task automatic wt(input int k);
    logic [3:0] v;
    for (int j = 0; j < W; j++) begin
      v = {scan_full_req, scan_part_req, store_req, stat.intrq};
      if (v[k] === 1'b1) return;
      cyc(1);
    end
    chk("wait done", 16'h0, 16'h1);
    final_report();
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      poh_tick = 1'b1;
      cyc(1);
      poh_tick = 1'b0;
      cyc(1);
    end
  endtask
  // One command; notes the expected answer unless refused
  task automatic issue(input logic [7:0] f, c, lo, hi,
                       input logic d, ab, cc, input logic [15:0] cy);
    tf = {f, c, lo, hi, 3'h0, d, 4'h0, CMD_RELIAB};
    cmd_stb = 1'b1;
    cyc(1);
    cmd_stb = 1'b0;
    if (d) begin
      repeat (5) begin
        chk("refused bsy", stat.bsy, 1'b0);
        cyc(1);
      end
      return;
    end
    exp_q.push_back({cc, ab, cy});
    chk("bsy drdy", {stat.bsy, stat.drdy}, 2'h2);
    wt(0);
    intrq_clr = 1'b1;
    cyc(1);
    intrq_clr = 1'b0;
    cyc(1);
  endtask
  // Answer watcher
  always @(posedge clk) begin
    if (stat.intrq === 1'b1 && iq_q !== 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("spurious", 16'h1, 16'h0);
      end else begin
        e = exp_q.pop_front();
        chk("abrt", stat.abrt, e[16]);
        chk("err", stat.err, e[16]);
        chk("done lines", {stat.bsy, stat.drdy}, 2'h1);
        if (e[17]) begin
          chk("cyl", {cyl_lo_out, cyl_hi_out}, e[15:0]);
        end
      end
    end
    iq_q <= stat.intrq;
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(99103));
    {cmd_stb, intrq_clr, nv_load, nv_mon_en, nv_as_en, nv_ao_en} = '0;
    {thresh_crossed, bg_store_req, poh_tick} = '0;
    tf = '0;
    rst = 1'b1;
    errors = 0;
    n_checks = 0;
    ast = '{CNT_OFF, 8'h55, CNT_AS_ON};
    cyc(6);
    rst = 1'b0;
    nv_mon_en = 1'b1;
    nv_load = 1'b1;
    cyc(1);
    nv_load = 1'b0;
    chk("mon", nv_mon_en_r, 1'b1);
    for (i = 0; i < 6; i++) begin
      thresh_crossed = (i < 2) ? i[0] : 1'($urandom);
      issue(SUB_STATUS, 8'($urandom), KEY_CYL_LO, KEY_CYL_HI, 0, 0, 1,
            thresh_crossed ? {BAD_CYL_LO, BAD_CYL_HI}
                           : {KEY_CYL_LO, KEY_CYL_HI});
    end
    issue(SUB_STATUS, 8'h00, 8'h00, KEY_CYL_HI, 0, 1, 0, 0);
    issue(SUB_SAVE, 8'h00, KEY_CYL_LO, 8'hC3, 0, 1, 0, 0);
    issue(8'h77, 8'h00, KEY_CYL_LO, KEY_CYL_HI, 0, 1, 0, 0);
    issue(SUB_SAVE, 8'h00, KEY_CYL_LO, KEY_CYL_HI, 0, 0, 0, 0);
    for (i = 0; i < 3; i++) begin
      issue(SUB_ATTRIBUTE_AUTO_STORE, ast[i], KEY_CYL_LO, KEY_CYL_HI, 0, i == 1, 0, 0);
      chk("attribute_auto_store", nv_as_en_r, i == 2);
    end
    issue(SUB_SAVE, 8'h00, KEY_CYL_LO, KEY_CYL_HI, 1, 0, 0, 0);
    bg_store_req = 1'b1;
    wt(1);
    bg_store_req = 1'b0;
    chk("bg bsy drdy", {stat.bsy, stat.drdy}, 2'h1);
    issue(SUB_SAVE, 8'h00, KEY_CYL_LO, KEY_CYL_HI, 0, 0, 0, 0);
    issue(SUB_AUTOOFF, CNT_AO_ON, KEY_CYL_LO, KEY_CYL_HI, 0, 0, 0, 0);
    chk("autooff", nv_ao_en_r, 1'b1);
    ticks(SCAN_PART_POH);
    wt(2);
    chk("scan bsy drdy", {stat.bsy, stat.drdy}, 2'h0);
    issue(SUB_SAVE, 8'h00, KEY_CYL_LO, KEY_CYL_HI, 0, 0, 0, 0);
    ticks(SCAN_FULL_POH - SCAN_PART_POH);
    wt(3);
    chk("autooff kept", nv_ao_en_r, 1'b1);
    issue(SUB_AUTOOFF, CNT_OFF, KEY_CYL_LO, KEY_CYL_HI, 0, 0, 0, 0);
    chk("autooff off", nv_ao_en_r, 1'b0);
    issue(SUB_AUTOOFF, CNT_AS_ON, KEY_CYL_LO, KEY_CYL_HI,
          0, 1, 0, 0);
    chk("autooff bad", nv_ao_en_r, 1'b0);
    issue(SUB_DISABLE, 8'h00, KEY_CYL_LO, KEY_CYL_HI, 0, 0, 0, 0);
    issue(SUB_STATUS, 8'h00, KEY_CYL_LO, KEY_CYL_HI, 0, 1, 0, 0);
    issue(SUB_ATTRIBUTE_AUTO_STORE, CNT_AS_ON, KEY_CYL_LO, KEY_CYL_HI,
          0, 1, 0, 0);
    issue(SUB_ENABLE, 8'h00, KEY_CYL_LO, KEY_CYL_HI, 0, 0, 0, 0);
    thresh_crossed = 1'b1;
    issue(SUB_STATUS, 8'h00, KEY_CYL_LO, KEY_CYL_HI, 0, 0, 1,
          {BAD_CYL_LO, BAD_CYL_HI});
    // Second reset, then reload of stored settings
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk("rst cyl", {cyl_lo_out, cyl_hi_out}, {KEY_CYL_LO, KEY_CYL_HI});
    nv_as_en = 1'b1;
    nv_load = 1'b1;
    cyc(1);
    nv_load = 1'b0;
    chk("reload attribute_auto_store", nv_as_en_r, 1'b1);
    cyc(5);
    final_report();
  end
endmodule
